// >>> rtl/dual_axis_position_sequencer.v
// Contract
// (RULE1) Jog bit drives open loop at speed
// (RULE2) Jog release loads actual as request
// (RULE3) Ready and start take new target
// (RULE4) In-position flag: window or start
// (RULE5) Sync bit makes axis 2 follow 1; the numeric method (nc_mode) ignores the sync correction
// (RULE6) Master supplies target and speed
// (RULE7) Stroke-dependent method adapts gain by distance
// (RULE8) Numeric method drives from profile error
// (RULE9) Fault forces programmed failsafe output
// (RULE10) Failsafe value and enable per axis
// (RULE11) Linear curve uses gain one
// (RULE12) Root curve three, reset default
// (RULE13) Root curve five near target
// (RULE14) Double gain replaces deadband step
// (RULE15) Fieldbus baud rate auto detected
// (RULE16) Process image 8 words each way
// (RULE17) Station address writable from both sides
// (RULE18) Indicator shows fieldbus online
// (RULE19) Ready needs both enables, no sensor error
// (RULE20) Enable sets target to actual
// (RULE21) Output clamped to full scale
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"

module dual_axis_position_sequencer #(
  parameter IDLE_CYCLES = `FB_IDLE_US * (`CLK_HZ / 1000000),
  parameter KNEE        = 256
) (
  input  wire               aclk,
  input  wire               aresetn,
  input  wire        [7:0]  s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output reg                s_axi_awready,
  input  wire        [31:0] s_axi_wdata,
  input  wire        [3:0]  s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output reg                s_axi_wready,
  output reg         [1:0]  s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire        [7:0]  s_axi_araddr,
  input  wire               s_axi_arvalid,
  output reg                s_axi_arready,
  output reg         [31:0] s_axi_rdata,
  output reg         [1:0]  s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  input  wire               hw_enable,
  input  wire        [1:0]  sensor_err,
  input  wire signed [15:0] pos1,
  input  wire signed [15:0] pos2,
  input  wire               bus_rx,
  input  wire               addr_set_valid,
  input  wire        [7:0]  addr_set_data,
  output wire signed [15:0] cmd1,
  output wire signed [15:0] cmd2,
  output wire        [1:0]  in_position_flag,
  output reg                ready_q,
  output reg                diag_online_q
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // (RULE16) eight output words
  reg  [15:0] img_q [0:7];
  reg  [31:0] cfg_q;
  reg  [15:0] window_q;
  reg  [15:0] fsv1_q;
  reg  [15:0] fsv2_q;
  reg  [15:0] db1_q;
  reg  [15:0] db2_q;
  reg  [7:0]  station_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg  [31:0] ctrl_q;
  reg  [15:0] baud_q;
  reg  [15:0] edge_cnt_q;
  reg  [31:0] idle_q;
  reg         rx_prev_q;
  reg         rdy_prev_q;

  // (RULE6) targets only from fieldbus image
  wire signed [15:0] tgt1 = img_q[1];
  wire        [15:0] spd1 = img_q[2];
  wire signed [15:0] tgt2 = img_q[3];
  wire        [15:0] spd2 = img_q[4];
  wire               sync = ctrl_q[`CB_SYNC];
  wire               avg  = ctrl_q[`CB_SYNC_AVG];
  wire signed [16:0] pdiff = {pos1[15], pos1} - {pos2[15], pos2};
  reg  signed [15:0] corr1;
  reg  signed [15:0] corr2;
  wire               fault1 = sensor_err[0] || !ready_q;
  wire               fault2 = sensor_err[1] || !ready_q;
  wire               wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
  wire               wr_img = (aw_addr_q[7:2] <= `OFS_OUT_LAST >> 2);

  // ---------------------------------------------------------------
  // Synchronisation
  // ---------------------------------------------------------------
  always @* begin
    corr1 = 16'h0000;
    corr2 = 16'h0000;
    if (sync) begin
      // (RULE5) outside numeric mode axis 2 follows axis 1, or with the average bit both axes meet halfway
      if (avg) begin
        corr1 = -pdiff[16:1];
        corr2 = pdiff[16:1];
      end else begin
        corr2 = pdiff[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Axis loops
  // ---------------------------------------------------------------
  // (RULE10) separate failsafe per axis
  axis_loop #(.KNEE(KNEE)) u_axis1 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ready     (ready_q),
    .jog       (ctrl_q[`CB_JOG]),
    .jog_dir   (ctrl_q[`CB_JOG_DIR]),
    .start     (ctrl_q[`CB_START]),
    .target    (tgt1),
    .speed     (spd1),
    .actual    (pos1),
    .sync_corr (corr1),
    .nc_mode   (cfg_q[`GB_NC]),
    .curve     (cfg_q[`GB_CURVE+1:`GB_CURVE]),
    .window    (window_q),
    .fs_en     (cfg_q[`GB_FS_EN]),
    .fs_val    (fsv1_q),
    .db_min    (db1_q),
    .fault     (fault1),
    .cmd_q     (cmd1),
    .in_pos_q  (in_position_flag[0])
  );

  axis_loop #(.KNEE(KNEE)) u_axis2 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ready     (ready_q),
    .jog       (ctrl_q[`CB_AX2+`CB_JOG]),
    .jog_dir   (ctrl_q[`CB_AX2+`CB_JOG_DIR]),
    .start     (ctrl_q[`CB_AX2+`CB_START]),
    .target    (tgt2),
    .speed     (spd2),
    .actual    (pos2),
    .sync_corr (corr2),
    .nc_mode   (cfg_q[`GB_AX2+`GB_NC]),
    .curve     (cfg_q[`GB_AX2+`GB_CURVE+1:`GB_AX2+`GB_CURVE]),
    .window    (window_q),
    .fs_en     (cfg_q[`GB_AX2+`GB_FS_EN]),
    .fs_val    (fsv2_q),
    .db_min    (db2_q),
    .fault     (fault2),
    .cmd_q     (cmd2),
    .in_pos_q  (in_position_flag[1])
  );

  // ---------------------------------------------------------------
  // Ready and fieldbus monitor
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      ready_q       <= 1'b0;
      rdy_prev_q    <= 1'b0;
      ctrl_q        <= 32'h0000_0000;
      diag_online_q <= 1'b0;
      baud_q        <= 16'hFFFF;
      edge_cnt_q    <= 16'h0000;
      idle_q        <= 32'h0000_0000;
      rx_prev_q     <= 1'b1;
    end else begin
      // (RULE19) both enables, no error
      ready_q    <= hw_enable && img_q[0][`CB_ENABLE] && (sensor_err == 2'b00);
      rdy_prev_q <= ready_q;
      // Control word: image word 0 in the low half, sync bits from image word 5 in the high half
      ctrl_q     <= {img_q[5], img_q[0]};
      rx_prev_q  <= bus_rx;
      // (RULE15) shortest pulse gives bit time
      if (bus_rx != rx_prev_q) begin
        edge_cnt_q <= 16'h0001;
        idle_q     <= 32'h0000_0000;
        if (edge_cnt_q < baud_q && edge_cnt_q != 16'h0000)
          baud_q <= edge_cnt_q;
      end else begin
        if (edge_cnt_q != 16'hFFFF)
          edge_cnt_q <= edge_cnt_q + 16'h0001;
        if (idle_q < IDLE_CYCLES)
          idle_q <= idle_q + 32'h0000_0001;
      end
      // Losing the line restarts detection so a slower rate can be found
      if (idle_q >= IDLE_CYCLES)
        baud_q <= 16'hFFFF;
      // (RULE18) online indicator
      diag_online_q <= (idle_q < IDLE_CYCLES) && (baud_q != 16'hFFFF);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write
  // ---------------------------------------------------------------
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      for (i = 0; i < 8; i = i + 1)
        img_q[i] <= 16'h0000;
      // (RULE12) root three default
      cfg_q     <= `RST_CFG;
      window_q  <= `RST_WINDOW;
      fsv1_q    <= 16'h0000;
      fsv2_q    <= 16'h0000;
      db1_q     <= 16'h0000;
      db2_q     <= 16'h0000;
      station_q <= `RST_STATION;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        if (wr_img) begin
          if (w_strb_q[0])
            img_q[aw_addr_q[4:2]][7:0] <= w_data_q[7:0];
          if (w_strb_q[1])
            img_q[aw_addr_q[4:2]][15:8] <= w_data_q[15:8];
        end else begin
          case (aw_addr_q)
            `OFS_CFG: begin
              if (w_strb_q[0])
                cfg_q[7:0] <= w_data_q[7:0];
              if (w_strb_q[1])
                cfg_q[15:8] <= w_data_q[15:8];
            end
            `OFS_WINDOW:  window_q <= w_data_q[15:0];
            `OFS_FSV1:    fsv1_q   <= w_data_q[15:0];
            `OFS_FSV2:    fsv2_q   <= w_data_q[15:0];
            `OFS_DB1:     db1_q    <= w_data_q[15:0];
            `OFS_DB2:     db2_q    <= w_data_q[15:0];
            // (RULE17) address from configuration side
            `OFS_STATION: station_q <= w_data_q[7:0];
            `OFS_STAT, `OFS_POS1, `OFS_POS2, `OFS_CMD1, `OFS_CMD2,
            `OFS_BAUD:    s_axi_bresp <= 2'b00;
            default:      s_axi_bresp <= (aw_addr_q <= `OFS_IN_LAST) ? 2'b00 : 2'b10;
          endcase
        end
      end
      // (RULE17) address set online
      if (addr_set_valid)
        station_q <= addr_set_data;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read
  // ---------------------------------------------------------------
  reg [31:0] rd_mux;
  reg        rd_err;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_axi_araddr <= `OFS_OUT_LAST) begin
      rd_mux = {16'h0000, img_q[s_axi_araddr[4:2]]};
    end else begin
      case (s_axi_araddr)
        // (RULE16) input image status word
        `OFS_STAT:    rd_mux = {26'h000_0000, diag_online_q, sensor_err,
                                in_position_flag, ready_q};
        `OFS_POS1:    rd_mux = {16'h0000, pos1};
        `OFS_POS2:    rd_mux = {16'h0000, pos2};
        `OFS_CMD1:    rd_mux = {16'h0000, cmd1};
        `OFS_CMD2:    rd_mux = {16'h0000, cmd2};
        `OFS_CFG:     rd_mux = {16'h0000, cfg_q[15:0]};
        `OFS_WINDOW:  rd_mux = {16'h0000, window_q};
        `OFS_FSV1:    rd_mux = {16'h0000, fsv1_q};
        `OFS_FSV2:    rd_mux = {16'h0000, fsv2_q};
        `OFS_DB1:     rd_mux = {16'h0000, db1_q};
        `OFS_DB2:     rd_mux = {16'h0000, db2_q};
        `OFS_STATION: rd_mux = {24'h00_0000, station_q};
        `OFS_BAUD:    rd_mux = {16'h0000, baud_q};
        default:      rd_err = (s_axi_araddr > `OFS_IN_LAST);
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_err ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // dual_axis_position_sequencer
`default_nettype wire

// >>> rtl/seq_map.vh
`ifndef SEQ_MAP_VH
`define SEQ_MAP_VH
// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define CLK_HZ         25000000
`define FB_IDLE_US     10000
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL       8'h00
`define OFS_TGT1       8'h04
`define OFS_SPD1       8'h08
`define OFS_TGT2       8'h0C
`define OFS_SPD2       8'h10
`define OFS_OUT_LAST   8'h1C
`define OFS_STAT       8'h20
`define OFS_POS1       8'h24
`define OFS_POS2       8'h28
`define OFS_CMD1       8'h2C
`define OFS_CMD2       8'h30
`define OFS_IN_LAST    8'h3C
`define OFS_CFG        8'h40
`define OFS_WINDOW     8'h44
`define OFS_FSV1       8'h48
`define OFS_FSV2       8'h4C
`define OFS_DB1        8'h50
`define OFS_DB2        8'h54
`define OFS_STATION    8'h58
`define OFS_BAUD       8'h5C
// ---------------------------------------------------------------
// Control word fields (axis 2 at +8)
// ---------------------------------------------------------------
`define CB_ENABLE      0
`define CB_JOG         1
`define CB_JOG_DIR     2
`define CB_START       3
`define CB_AX2         8
`define CB_SYNC        16
`define CB_SYNC_AVG    17
// ---------------------------------------------------------------
// Config word fields (axis 2 at +8)
// ---------------------------------------------------------------
`define GB_NC          0
`define GB_CURVE       1
`define GB_FS_EN       3
`define GB_AX2         8
// Curve codes
`define CURVE_LIN      2'h0
`define CURVE_ROOT3    2'h1
`define CURVE_ROOT5    2'h2
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_CFG        32'h0000_0A0A
`define RST_WINDOW     16'h0010
`define RST_STATION    8'h7E
`endif

// >>> rtl/axis_loop.v
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"

module axis_loop #(
  parameter KNEE     = 256,
  parameter NC_SHIFT = 4
) (
  input  wire               aclk,
  input  wire               aresetn,
  input  wire               ready,
  input  wire               jog,
  input  wire               jog_dir,
  input  wire               start,
  input  wire signed [15:0] target,
  input  wire        [15:0] speed,
  input  wire signed [15:0] actual,
  input  wire signed [15:0] sync_corr,
  input  wire               nc_mode,
  input  wire         [1:0] curve,
  input  wire        [15:0] window,
  input  wire               fs_en,
  input  wire signed [15:0] fs_val,
  input  wire        [15:0] db_min,
  input  wire               fault,
  output reg  signed [15:0] cmd_q,
  output reg                in_pos_q
);
  reg signed [15:0] req_q;
  reg signed [23:0] prof_q;
  reg               jog_prev_q;
  reg               rdy_prev_q;

  wire signed [23:0] act_x  = {{8{actual[15]}}, actual};
  wire signed [23:0] req_x  = {{8{req_q[15]}}, req_q};
  wire signed [23:0] spd_x  = {8'h00, speed};
  wire signed [23:0] err    = req_x - act_x + {{8{sync_corr[15]}}, sync_corr};
  wire        [23:0] abs_e  = err[23] ? -err : err;
  wire signed [23:0] step   = {{NC_SHIFT{1'b0}}, spd_x[23:NC_SHIFT]};
  wire signed [23:0] pdiff  = req_x - prof_q;
  wire signed [23:0] f_err  = prof_q - act_x;
  wire        [23:0] pos_d  = (req_x > act_x) ? req_x - act_x : act_x - req_x;
  reg         [2:0]  mult;
  reg  signed [23:0] raw;
  reg  signed [23:0] shaped;
  reg  signed [23:0] db_x;

  // ---------------------------------------------------------------
  // Braking gain
  // ---------------------------------------------------------------
  always @* begin
    // (RULE7) distance sets gain
    mult = 3'd1;
    case (curve)
      // (RULE11) linear gain one
      `CURVE_LIN:   mult = 3'd1;
      // (RULE12) root gain three
      `CURVE_ROOT3: mult = (abs_e < KNEE) ? 3'd3 : (abs_e < 2 * KNEE) ? 3'd2 : 3'd1;
      // (RULE13) root gain five
      `CURVE_ROOT5: mult = (abs_e < KNEE) ? 3'd5 : (abs_e < 2 * KNEE) ? 3'd3 : 3'd1;
      default:      mult = 3'd1;
    endcase
  end

  // ---------------------------------------------------------------
  // Output path
  // ---------------------------------------------------------------
  always @* begin
    db_x = {8'h00, db_min};
    if (nc_mode) begin
      // (RULE8) following error drive
      raw = f_err <<< 2;
    end else begin
      raw = err * $signed({21'h0, mult});
    end
    if (raw > spd_x)
      raw = spd_x;
    else if (raw < -spd_x)
      raw = -spd_x;
    if (jog) begin
      // (RULE1) open loop jog
      raw = jog_dir ? spd_x : -spd_x;
    end
    // (RULE14) double gain deadband
    if (raw > db_x || raw < -db_x)
      shaped = raw[23] ? raw - db_x : raw + db_x;
    else
      shaped = raw <<< 1;
    // (RULE9) failsafe on fault
    if (fault && fs_en)
      shaped = {{8{fs_val[15]}}, fs_val};
    else if (!ready)
      shaped = 24'h00_0000;
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      req_q      <= 16'h0000;
      prof_q     <= 24'h00_0000;
      jog_prev_q <= 1'b0;
      rdy_prev_q <= 1'b0;
      cmd_q      <= 16'h0000;
      in_pos_q   <= 1'b0;
    end else begin
      jog_prev_q <= jog;
      rdy_prev_q <= ready;
      if (ready && !rdy_prev_q) begin
        // (RULE20) hold at actual
        req_q  <= actual;
        prof_q <= act_x;
      end else if (jog || (jog_prev_q && !jog)) begin
        // (RULE2) take actual position
        req_q  <= actual;
        prof_q <= act_x;
      end else if (ready && start) begin
        // (RULE3) take new target
        req_q <= target;
      end
      if (!jog && ready && !(ready && !rdy_prev_q)) begin
        if (pdiff > step)
          prof_q <= prof_q + step;
        else if (pdiff < -step)
          prof_q <= prof_q - step;
        else
          prof_q <= req_x;
      end
      // (RULE21) clamp to full scale
      if (shaped > 24'sh00_7FFF)
        cmd_q <= 16'h7FFF;
      else if (shaped < -24'sh00_7FFF)
        cmd_q <= 16'h8001;
      else
        cmd_q <= shaped[15:0];
      // (RULE4) window or start
      in_pos_q <= (pos_d <= {8'h00, window}) || start;
    end
  end
endmodule // axis_loop
`default_nettype wire

// >>> testbench/seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module seq_props #(
  parameter int IDLE_CYCLES = 200
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic        [1:0]  s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic        [7:0]  s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic        [31:0] s_axi_rdata,
  input wire logic        [1:0]  s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               hw_enable,
  input wire logic        [1:0]  sensor_err,
  input wire logic               bus_rx,
  input wire logic signed [15:0] cmd1,
  input wire logic signed [15:0] cmd2,
  input wire logic               ready_q,
  input wire logic               diag_online_q
);
  int   idle_q;
  logic rx_q;
  // ----
  // Line idle counter
  // ----
  always_ff @(posedge aclk) begin
    rx_q <= bus_rx;
    if (!aresetn || bus_rx != rx_q)
      idle_q <= 0;
    else if (idle_q < 100000)
      idle_q <= idle_q + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ready_cause: assert property (ready_q |-> $past(hw_enable) && $past(sensor_err) == 2'b00)
    else $error("ready without enable or with sensor error");
  a_error_drops: assert property (|sensor_err |=> !ready_q)
    else $error("ready stays up on sensor error");
  a_cmd_clamp: assert property (cmd1 != 16'h8000 && cmd2 != 16'h8000)
    else $error("axis output beyond full scale");
  a_idle_offline: assert property (idle_q > IDLE_CYCLES + 4 |-> !diag_online_q)
    else $error("online indicator on an idle line");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles later");
  a_busy_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_r_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h5C
    |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  c_ready: cover property (ready_q);
  c_online: cover property (diag_online_q);
  c_unmapped: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h5C);
endmodule // seq_props
bind dual_axis_position_sequencer seq_props #(.IDLE_CYCLES(IDLE_CYCLES)) u_seq_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .hw_enable, .sensor_err, .bus_rx, .cmd1, .cmd2, .ready_q, .diag_online_q);
`default_nettype wire

// >>> testbench/fb_master.sv
`timescale 1ns/1ps
`default_nettype none
module fb_master (
  input  wire logic       aclk,
  input  wire logic       run,
  input  wire logic [7:0] bit_cycles,
  output var  logic       bus_rx
);
  logic [7:0] cnt_q;
  initial bus_rx = 1'b1;
  always @(posedge aclk) begin
    if (!run && bus_rx) begin
      cnt_q <= 8'h00;
      bus_rx <= 1'b1;
    end else if (cnt_q == bit_cycles - 8'h01) begin
      cnt_q <= 8'h00;
      bus_rx <= ~bus_rx;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // fb_master
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.vh"
module testbench;
  localparam int IDLE = 200;
  localparam int KNEE = 256;
  logic               aclk = 0, aresetn = 0, run = 0, hw_enable = 0, addr_set_valid = 0;
  logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic               s_axi_arvalid = 0, s_axi_rready = 0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic               ready_q, diag_online_q, bus_rx;
  logic        [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, addr_set_data = 0, bit_cycles = 12;
  logic        [31:0] s_axi_wdata = 0, s_axi_rdata, rdv;
  logic        [3:0]  s_axi_wstrb = 4'hF;
  logic        [1:0]  sensor_err = 0, s_axi_bresp, s_axi_rresp, rsp_q, in_position_flag;
  logic signed [15:0] pos1 = 0, pos2 = 0, cmd1, cmd2;
  int                 n_fail = 0, num_checks = 0, cyc = 0, p, j0, v;
  int                 ev[6] = '{100, 100, 100, 300, 300, 1000};
  int                 cv[6] = '{0, 1, 2, 1, 2, 1};
  dual_axis_position_sequencer #(.IDLE_CYCLES(IDLE), .KNEE(KNEE)) u_dual_axis_position_sequencer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .hw_enable, .sensor_err, .pos1, .pos2, .bus_rx,
    .addr_set_valid, .addr_set_data, .cmd1, .cmd2, .in_position_flag, .ready_q,
    .diag_online_q);
  fb_master u_fb_master (.aclk, .run, .bit_cycles, .bus_rx);
  always #20 aclk = ~aclk;
  function automatic logic [31:0] w16(input int x);
    return {16'h0000, x[15:0]};
  endfunction
  // Gain by curve and distance, speed limit, then deadband double gain
  function automatic logic [31:0] model(input int e, input int c, input int s, input int d);
    int a, g, x;
    a = e < 0 ? -e : e;
    g = c == 0 ? 1 : a < KNEE ? (c == 1 ? 3 : 5) : a < 2 * KNEE ? (c == 1 ? 2 : 3) : 1;
    x = g * e;
    x = x > s ? s : x < -s ? -s : x;
    a = x < 0 ? -x : x;
    x = a <= d ? 2 * x : x + (x < 0 ? -d : d);
    return w16(x);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ----
  // Bus master: valid held until its own ready
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp_q = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp_q = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // Hang guard well above the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h0adc_f67e));
    p = int'($urandom_range(16000)) - 8000;
    pos1 = p[15:0];
    pos2 = w16(p - 200);
    tk(2);
    aresetn <= 1;
    tk(1);
    rd(`OFS_CFG);
    chk(rdv, `RST_CFG);
    rd(`OFS_WINDOW);
    chk(rdv, {16'h0000, `RST_WINDOW});
    rd(`OFS_BAUD);
    chk(rdv, 32'h0000_FFFF);
    rd(8'h60);
    chk({30'h0, rsp_q}, 2);
    wr(8'h60, 32'h0000_0000);
    chk({30'h0, rsp_q}, 2);
    v = $urandom;
    wr(`OFS_OUT_LAST, v);
    rd(`OFS_OUT_LAST);
    chk(rdv, w16(v));
    rd(`OFS_IN_LAST);
    chk(rdv, 32'h0000_0000);
    rd(`OFS_STATION);
    chk(rdv, {24'h0, `RST_STATION});
    wr(`OFS_STATION, 32'h0000_0033);
    rd(`OFS_STATION);
    chk(rdv, 32'h0000_0033);
    addr_set_data <= 8'h45;
    addr_set_valid <= 1;
    tk(1);
    addr_set_valid <= 0;
    rd(`OFS_STATION);
    chk(rdv, 32'h0000_0045);
    hw_enable <= 1;
    wr(`OFS_CTRL, 32'h0000_0001);
    tk(4);
    chk({31'h0, ready_q}, 1);
    chk({31'h0, in_position_flag[0]}, 1);
    chk({16'h0, cmd1}, 0);
    sensor_err <= 2'b10;
    tk(3);
    chk({31'h0, ready_q}, 0);
    sensor_err <= 2'b00;
    wr(`OFS_DB1, 32'h0000_0000);
    wr(`OFS_SPD1, 32'h0000_0320);
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_CFG, 32'h0000_0A08 | (cv[i] << 1));
      wr(`OFS_TGT1, w16(p + ev[i]));
      wr(`OFS_CTRL, 32'h0000_0009);
      tk(4);
      chk({16'h0, cmd1}, model(ev[i], cv[i], 800, 0));
      chk({31'h0, in_position_flag[0]}, 1);
    end
    wr(`OFS_CFG, 32'h0000_0A08);
    wr(`OFS_DB1, 32'h0000_0032);
    wr(`OFS_TGT1, w16(p + 30));
    tk(4);
    chk({16'h0, cmd1}, model(30, 0, 800, 50));
    wr(`OFS_CTRL, 32'h0000_0001);
    tk(4);
    chk({31'h0, in_position_flag[0]}, 0);
    wr(`OFS_DB1, 32'h0000_0000);
    wr(`OFS_CTRL, 32'h0000_0003);
    tk(4);
    j0 = cmd1;
    chk(w16(j0 < 0 ? -j0 : j0), w16(800));
    wr(`OFS_CTRL, 32'h0000_0007);
    tk(4);
    chk({16'h0, cmd1}, w16(-j0));
    wr(`OFS_CTRL, 32'h0000_0001);
    tk(4);
    chk({31'h0, in_position_flag[0]}, 1);
    chk({16'h0, cmd1}, 0);
    wr(`OFS_CTRL, 32'h0000_0101);
    tk(4);
    chk({16'h0, cmd2}, 0);
    wr(`OFS_SPD2, 32'h0000_0320);
    wr(8'h14, 32'h0000_0001);
    tk(4);
    chk({16'h0, cmd2}, model(200, 1, 800, 0));
    wr(8'h14, 32'h0000_0000);
    v = $urandom_range(4000);
    wr(`OFS_FSV1, v);
    wr(`OFS_FSV2, v + 7);
    hw_enable <= 0;
    tk(4);
    chk({31'h0, ready_q}, 0);
    chk({16'h0, cmd1}, w16(v));
    wr(`OFS_CFG, 32'h0000_0800);
    tk(4);
    chk({16'h0, cmd1}, 0);
    chk({16'h0, cmd2}, w16(v + 7));
    hw_enable <= 1;
    run <= 1;
    tk(300);
    run <= 0;
    rd(`OFS_BAUD);
    chk(rdv, 32'h0000_000C);
    chk({31'h0, diag_online_q}, 1);
    tk(IDLE + 20);
    chk({31'h0, diag_online_q}, 0);
    conclude();
  end
endmodule // testbench
`default_nettype wire
